// File: rtl/margin_consts.svh
// constants for the margin converter serial slave and its bus master
`ifndef MARGIN_CONSTS_SVH
`define MARGIN_CONSTS_SVH
`define MARGIN_CODE_OFS 8'he3
`define MARGIN_CTRL_OFS 8'he4
`define MARGIN_CODE_RST 8'h00
`define MARGIN_CTRL_RST 8'h00
`define MARGIN_CTRL_MASK 8'h3f
`define HS_SEL_MSB 5
`define HS_SEL_LSB 3
`define LOAD_BIT 2
`define OUT_DRIVE_BIT 1
`define POWER_BIT 0
`define ADDR_PREFIX 1'b1
`define SYS_CLK_MHZ 250
`define SMBUS_CLK_KHZ 100
`define SCL_QUARTER_CYCLES ((`SYS_CLK_MHZ * 1000) / (4 * `SMBUS_CLK_KHZ))
`define PWRUP_CYCLES 16
`endif

// File: rtl/margin_pkg.sv
// state types shared by both ends of the margin serial link
package margin_pkg;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_ADDR  = 7'b000_0010,
    ST_WADDR = 7'b000_0100,
    ST_WDATA = 7'b000_1000,
    ST_ACK   = 7'b001_0000,
    ST_RDATA = 7'b010_0000,
    ST_RACK  = 7'b100_0000
  } dev_state_t;
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_START = 4'b0010,
    H_BYTE  = 4'b0100,
    H_STOP  = 4'b1000
  } host_state_t;
endpackage

// File: rtl/margin_bus_if.sv
// open-drain two-wire bus joining the master and the slave
`timescale 1ns/100ps
`default_nettype none
interface margin_bus_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // pulled high unless some driver pulls low
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// File: rtl/margin_slave_dev.sv
// device end: two-wire slave with the margin converter registers
`timescale 1ns/100ps
`default_nettype none
`include "margin_consts.svh"
module margin_slave_dev #(
  parameter int PWRUP_CYCLES = `PWRUP_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  margin_bus_if.dev bus,
  input wire logic [1:0] addr_strap_high,
  input wire logic [1:0] addr_strap_mid,
  input wire logic [1:0] addr_strap_low,
  output logic [7:0] margin_code,
  output logic [2:0] half_scale_select,
  output logic output_drive_enable,
  output logic converter_powered,
  output logic [21:0] margin_out_uv
);
  import margin_pkg::*;

  localparam int PW = $clog2(PWRUP_CYCLES + 1);

  generate
    if (PWRUP_CYCLES < 1) begin : g_chk
      $error("PWRUP_CYCLES must be at least one");
    end
  endgenerate

  // half-scale level in millivolts
  function automatic logic [10:0] half_scale_mv(input logic [2:0] sel);
    case (sel)
      3'h0: half_scale_mv = 11'h190;
      3'h1: half_scale_mv = 11'h1f4;
      3'h2: half_scale_mv = 11'h258;
      3'h3: half_scale_mv = 11'h2bc;
      3'h4: half_scale_mv = 11'h320;
      3'h5: half_scale_mv = 11'h384;
      3'h6: half_scale_mv = 11'h3e8;
      default: half_scale_mv = 11'h4b0;
    endcase
  endfunction

  // output in microvolts: code * 2 * half-scale / 256
  function automatic logic [21:0] level_uv(input logic [7:0] code, input logic [2:0] sel);
    logic [31:0] p;
    p = 32'(code) * 32'(half_scale_mv(sel)) * 32'h0000_007d;
    level_uv = p[25:4];
  endfunction

  // register contents as a two-byte word, upper byte zero
  function automatic logic [15:0] read_word(input logic [7:0] ptr, input logic [7:0] code,
                                            input logic [7:0] ctrl);
    if (ptr == `MARGIN_CODE_OFS) begin
      read_word = {8'h00, code};
    end else if (ptr == `MARGIN_CTRL_OFS) begin
      read_word = {8'h00, ctrl};
    end else begin
      read_word = 16'h0000;
    end
  endfunction

  dev_state_t state_q, state_d, after_q, after_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d, hi_q, hi_d, ptr_q, ptr_d;
  logic [15:0] tx_q, tx_d;
  logic ack_q, ack_d, mack_q, mack_d, sel_q, sel_d, sda_oe_q, sda_oe_d;
  logic scl_q, sda_q, ready_q, ready_d;
  logic [PW-1:0] pwr_q, pwr_d;
  logic [7:0] code_q, code_d, ctrl_q, ctrl_d, loaded_q, loaded_d;
  logic [21:0] uv_q, uv_d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [15:0] wr_data;
  logic [7:0] rx_byte;
  logic [6:0] own_addr;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  assign own_addr = {`ADDR_PREFIX, addr_strap_high, addr_strap_mid, addr_strap_low};
  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign start_seen = ready_q & bus.scl & scl_q & sda_q & ~bus.sda;
  assign stop_seen = bus.scl & scl_q & ~sda_q & bus.sda;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = sda_oe_q;
  assign margin_code = loaded_q;
  assign half_scale_select = ctrl_q[`HS_SEL_MSB:`HS_SEL_LSB];
  assign output_drive_enable = ctrl_q[`OUT_DRIVE_BIT];
  assign converter_powered = ctrl_q[`POWER_BIT];
  assign margin_out_uv = uv_q;

  // serial engine, slave only, clocked by sys_clk and stepped on sampled edges of the master's clock
  always_comb begin
    state_d = state_q;
    after_d = after_q;
    bit_d = bit_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ack_d = ack_q;
    mack_d = mack_q;
    sel_d = sel_q;
    hi_d = hi_q;
    ptr_d = ptr_q;
    sda_oe_d = sda_oe_q;
    wr_en = 1'b0;
    wr_addr = ptr_q;
    wr_data = 16'h0000;
    rx_byte = {shift_q[6:0], bus.sda};
    ready_d = ready_q;
    pwr_d = pwr_q;
    if (!ready_q) begin
      pwr_d = pwr_q + PW'(1);
      ready_d = (pwr_q == PW'(PWRUP_CYCLES - 1));
    end
    if (start_seen) begin
      state_d = ST_ADDR;
      bit_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_seen) begin
      state_d = ST_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WADDR, ST_WDATA: begin
          if (scl_rise && bit_q != 4'h8) begin
            shift_d = rx_byte;
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              ack_d = 1'b1;
              sel_d = 1'b0;
              if (state_q == ST_ADDR) begin
                if (rx_byte[7:1] == own_addr) begin
                  after_d = rx_byte[0] ? ST_RDATA : ST_WADDR;
                  tx_d = read_word(ptr_q, code_q, ctrl_q);
                end else begin
                  ack_d = 1'b0;
                  after_d = ST_IDLE;
                end
              end else if (state_q == ST_WADDR) begin
                ptr_d = rx_byte;
                after_d = ST_WDATA;
              end else if (!sel_q) begin
                hi_d = rx_byte;
                sel_d = 1'b1;
                after_d = ST_WDATA;
              end else begin
                wr_en = 1'b1;
                wr_data = {hi_q, rx_byte};
                after_d = ST_IDLE;
              end
            end
          end else if (scl_fall && bit_q == 4'h8) begin
            sda_oe_d = ack_q;
            state_d = ack_q ? ST_ACK : ST_IDLE;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_d = 4'h0;
            state_d = after_q;
            sda_oe_d = (after_q == ST_RDATA) ? ~tx_q[15] : 1'b0;
          end
        end
        ST_RDATA: begin
          if (scl_rise && bit_q != 4'h8) begin
            bit_d = bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == 4'h8) begin
              sda_oe_d = 1'b0;
              state_d = ST_RACK;
            end else begin
              tx_d = {tx_q[14:0], 1'b0};
              sda_oe_d = ~tx_q[14];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            mack_d = ~bus.sda;
          end else if (scl_fall) begin
            bit_d = 4'h0;
            state_d = mack_q ? ST_RDATA : ST_IDLE;
            if (sel_q) begin
              ptr_d = ptr_q + 8'h01;
              tx_d = read_word(ptr_q + 8'h01, code_q, ctrl_q);
              sel_d = 1'b0;
            end else begin
              tx_d = {tx_q[14:0], 1'b0};
              sel_d = 1'b1;
            end
            sda_oe_d = mack_q & ~tx_d[15];
          end
        end
        ST_IDLE: begin
        end
        default: begin
          state_d = ST_IDLE;
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      after_q <= ST_IDLE;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 16'h0000;
      ack_q <= 1'b0;
      mack_q <= 1'b0;
      sel_q <= 1'b0;
      hi_q <= 8'h00;
      ptr_q <= 8'h00;
      sda_oe_q <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ready_q <= 1'b0;
      pwr_q <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      after_q <= after_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ack_q <= ack_d;
      mack_q <= mack_d;
      sel_q <= sel_d;
      hi_q <= hi_d;
      ptr_q <= ptr_d;
      sda_oe_q <= sda_oe_d;
      scl_q <= bus.scl;
      sda_q <= bus.sda;
      ready_q <= ready_d;
      pwr_q <= pwr_d;
    end
  end

  // margin registers and converter model
  always_comb begin
    code_d = code_q;
    ctrl_d = ctrl_q;
    loaded_d = loaded_q;
    if (wr_en && wr_addr == `MARGIN_CODE_OFS) begin
      code_d = wr_data[7:0];
    end
    if (wr_en && wr_addr == `MARGIN_CTRL_OFS) begin
      ctrl_d = wr_data[7:0] & `MARGIN_CTRL_MASK;
      if (wr_data[`LOAD_BIT] && !ctrl_q[`LOAD_BIT]) begin
        loaded_d = code_q;
      end
    end
    uv_d = 22'h00_0000;
    if (ctrl_q[`POWER_BIT] && ctrl_q[`OUT_DRIVE_BIT]) begin
      uv_d = level_uv(loaded_q, ctrl_q[`HS_SEL_MSB:`HS_SEL_LSB]);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      code_q <= `MARGIN_CODE_RST;
      ctrl_q <= `MARGIN_CTRL_RST;
      loaded_q <= `MARGIN_CODE_RST;
      uv_q <= 22'h00_0000;
    end else if (clk_en) begin
      code_q <= code_d;
      ctrl_q <= ctrl_d;
      loaded_q <= loaded_d;
      uv_q <= uv_d;
    end
  end
endmodule
`default_nettype wire

// File: rtl/margin_host_master.sv
// host end: two-wire bus master issuing word reads and writes
`timescale 1ns/100ps
`default_nettype none
`include "margin_consts.svh"
module margin_host_master #(
  parameter int QUARTER_CYCLES = `SCL_QUARTER_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  margin_bus_if.host bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic [6:0] cmd_slave_addr,
  input wire logic [7:0] cmd_word_addr,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic rsp_nack,
  output logic [15:0] rsp_rdata
);
  import margin_pkg::*;

  localparam int CW = $clog2(QUARTER_CYCLES + 1);

  generate
    if (QUARTER_CYCLES < 2) begin : g_chk
      $error("QUARTER_CYCLES must be at least two");
    end
  endgenerate

  // byte sent at each position of the sequence
  function automatic logic [7:0] host_byte(input logic [2:0] idx, input logic rd,
                                           input logic [6:0] sa, input logic [7:0] wa,
                                           input logic [15:0] wd);
    case (idx)
      3'h0: host_byte = {sa, 1'b0};
      3'h1: host_byte = wa;
      3'h2: host_byte = rd ? {sa, 1'b1} : wd[15:8];
      3'h3: host_byte = wd[7:0];
      default: host_byte = 8'h00;
    endcase
  endfunction

  host_state_t st_q, st_d;
  logic [1:0] ph_q, ph_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [2:0] idx_q, idx_d;
  logic rd_q, rd_d, nack_q, nack_d, scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic ready_q, ready_d, rv_q, rv_d;
  logic [6:0] sa_q, sa_d;
  logic [7:0] wa_q, wa_d, txb;
  logic [15:0] wd_q, wd_d, rx_q, rx_d, rr_q, rr_d;
  logic tick, sending;

  assign tick = (cnt_q == '0);
  assign txb = host_byte(idx_q, rd_q, sa_q, wa_q, wd_q);
  assign sending = rd_q ? (idx_q <= 3'h2) : 1'b1;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_scl_oe = scl_oe_q;
  assign bus.host_sda_oe = sda_oe_q;
  assign cmd_ready = ready_q;
  assign rsp_valid = rv_q;
  assign rsp_nack = nack_q;
  assign rsp_rdata = rr_q;

  always_comb begin
    st_d = st_q;
    ph_d = ph_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    idx_d = idx_q;
    rd_d = rd_q;
    nack_d = nack_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    ready_d = ready_q;
    rv_d = 1'b0;
    sa_d = sa_q;
    wa_d = wa_q;
    wd_d = wd_q;
    rx_d = rx_q;
    rr_d = rr_q;
    if (st_q == H_IDLE) begin
      if (cmd_valid && ready_q) begin
        st_d = H_START;
        ph_d = 2'h0;
        cnt_d = CW'(QUARTER_CYCLES - 1);
        idx_d = 3'h0;
        rd_d = cmd_read;
        sa_d = cmd_slave_addr;
        wa_d = cmd_word_addr;
        wd_d = cmd_wdata;
        nack_d = 1'b0;
        ready_d = 1'b0;
      end
    end else if (!tick) begin
      cnt_d = cnt_q - CW'(1);
    end else begin
      cnt_d = CW'(QUARTER_CYCLES - 1);
      ph_d = ph_q + 2'h1;
      case (st_q)
        H_START: begin
          case (ph_q)
            2'h0: sda_oe_d = 1'b0;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b1;
            default: begin
              scl_oe_d = 1'b1;
              st_d = H_BYTE;
              bit_d = 4'h0;
            end
          endcase
        end
        H_BYTE: begin
          case (ph_q)
            2'h0: begin
              if (bit_q != 4'h8) begin
                sda_oe_d = sending & ~txb[3'(4'h7 - bit_q)];
              end else begin
                sda_oe_d = ~sending & (idx_q == 3'h3);
              end
            end
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q != 4'h8 && !sending) begin
                rx_d = {rx_q[14:0], bus.sda};
              end else if (bit_q == 4'h8 && sending) begin
                nack_d = bus.sda;
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d = 4'h0;
                idx_d = idx_q + 3'h1;
                if (sending && nack_d) begin
                  st_d = H_STOP;
                end else if (rd_q && idx_q == 3'h1) begin
                  st_d = H_START;
                end else if (idx_q == (rd_q ? 3'h4 : 3'h3)) begin
                  st_d = H_STOP;
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: begin
              st_d = H_IDLE;
              ready_d = 1'b1;
              rv_d = 1'b1;
              rr_d = rx_q;
            end
          endcase
        end
        default: st_d = H_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= H_IDLE;
      ph_q <= 2'h0;
      cnt_q <= '0;
      bit_q <= 4'h0;
      idx_q <= 3'h0;
      rd_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      ready_q <= 1'b1;
      rv_q <= 1'b0;
      sa_q <= 7'h00;
      wa_q <= 8'h00;
      wd_q <= 16'h0000;
      rx_q <= 16'h0000;
      rr_q <= 16'h0000;
    end else if (clk_en) begin
      st_q <= st_d;
      ph_q <= ph_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      idx_q <= idx_d;
      rd_q <= rd_d;
      nack_q <= nack_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      ready_q <= ready_d;
      rv_q <= rv_d;
      sa_q <= sa_d;
      wa_q <= wa_d;
      wd_q <= wd_d;
      rx_q <= rx_d;
      rr_q <= rr_d;
    end
  end
endmodule
`default_nettype wire

// File: dv/margin_link_properties.sv
// concurrent checks on the two-wire link between master and slave
`timescale 1ns/100ps
`default_nettype none
module margin_link_properties #(
  parameter int PWRUP_CYCLES = 16
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  localparam int FRAME_MAX = 2000;
  logic scl_p_q, sda_p_q, idle_q, busy_q, rw_q;
  logic [15:0] pwr_q;
  logic [3:0] bit_q;
  logic [11:0] frame_q;
  logic start_ev, stop_ev, scl_rise;
  assign start_ev = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_ev = scl & scl_p_q & ~sda_p_q & sda;
  assign scl_rise = scl & ~scl_p_q;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      idle_q <= 1'b1;
      busy_q <= 1'b0;
      rw_q <= 1'b0;
      pwr_q <= '0;
      bit_q <= '0;
      frame_q <= '0;
    end else begin
      scl_p_q <= scl;
      sda_p_q <= sda;
      if (pwr_q < 16'(PWRUP_CYCLES)) pwr_q <= pwr_q + 16'h0001;
      if (start_ev) idle_q <= (pwr_q < 16'(PWRUP_CYCLES));
      else if (stop_ev) idle_q <= 1'b1;
      if (start_ev) busy_q <= 1'b1;
      else if (stop_ev) busy_q <= 1'b0;
      if (start_ev) bit_q <= '0;
      else if (scl_rise && bit_q != 4'hf) bit_q <= bit_q + 4'h1;
      if (scl_rise && bit_q == 4'h7) rw_q <= sda;
      if (!busy_q) frame_q <= '0;
      else if (frame_q != 12'hfff) frame_q <= frame_q + 12'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_quiet_outside_frame;
    idle_q |-> !dev_sda_oe;
  endproperty
  a_quiet_outside_frame: assert property (p_quiet_outside_frame)
    else $error("slave drives data outside a frame");
  property p_change_after_fall;
    $changed(dev_sda_oe) |-> $past(scl, 2) && !$past(scl);
  endproperty
  a_change_after_fall: assert property (p_change_after_fall)
    else $error("slave data change not one clock after clock fall");
  property p_steady_while_high;
    scl && $past(scl) |-> $stable(dev_sda_oe);
  endproperty
  a_steady_while_high: assert property (p_steady_while_high)
    else $error("slave data moved while clock high");
  property p_addr_listen;
    scl_rise && bit_q < 4'h8 |-> !dev_sda_oe;
  endproperty
  a_addr_listen: assert property (p_addr_listen)
    else $error("slave drove during address byte");
  property p_frame_bounded;
    frame_q <= 12'(FRAME_MAX);
  endproperty
  a_frame_bounded: assert property (p_frame_bounded)
    else $error("frame without stop too long");
  property p_ack_released;
    scl_rise && bit_q == 4'h8 && !rw_q && dev_sda_oe |-> ##[1:20] !dev_sda_oe;
  endproperty
  a_ack_released: assert property (p_ack_released)
    else $error("write acknowledge not released");
  property p_clock_from_master;
    $fell(scl) |-> busy_q;
  endproperty
  a_clock_from_master: assert property (p_clock_from_master)
    else $error("clock toggled outside a started frame");
  property p_stop_released;
    stop_ev |-> !dev_sda_oe && !$past(dev_sda_oe);
  endproperty
  a_stop_released: assert property (p_stop_released)
    else $error("slave holding data at stop");
  c_start: cover property (start_ev && !idle_q);
  c_ack: cover property (scl_rise && bit_q == 4'h8 && dev_sda_oe && !dev_sda_o);
  c_read_bit: cover property (scl_rise && bit_q > 4'h8 && dev_sda_oe && rw_q);
  c_stop: cover property (stop_ev && !host_sda_oe && host_sda_o == 1'b0);
endmodule
`default_nettype wire

// File: dv/margin_dac_serial_slave_tb_top.sv
// self-checking bench: master and slave joined over the two-wire link
`timescale 1ns/100ps
`default_nettype none
`include "margin_consts.svh"
module margin_dac_serial_slave_tb_top;
  import margin_pkg::*;
  typedef struct packed {
    logic rd;
    logic nack;
    logic [15:0] data;
  } note_t;
  logic sys_clk = 1'b0;
  logic sys_rst, clk_en, cmd_valid, cmd_read, cmd_ready, rsp_valid, rsp_nack;
  logic [6:0] cmd_slave_addr, own_addr;
  logic [7:0] cmd_word_addr, margin_code, code_m, ctrl_m, loaded_m;
  logic [15:0] cmd_wdata, rsp_rdata;
  logic [1:0] strap_high, strap_mid, strap_low;
  logic [2:0] half_scale_select;
  logic output_drive_enable, converter_powered;
  logic [21:0] margin_out_uv;
  logic [31:0] rng_state;
  int err_total, samples_checked;
  note_t notes[$];
  note_t seen_note;
  margin_bus_if bus_i ();
  margin_host_master #(.QUARTER_CYCLES(4)) u_margin_host_master (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus_i), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_slave_addr(cmd_slave_addr), .cmd_word_addr(cmd_word_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));
  margin_slave_dev #(.PWRUP_CYCLES(16)) u_margin_slave_dev (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .bus(bus_i), .addr_strap_high(strap_high),
    .addr_strap_mid(strap_mid), .addr_strap_low(strap_low), .margin_code(margin_code),
    .half_scale_select(half_scale_select), .output_drive_enable(output_drive_enable),
    .converter_powered(converter_powered), .margin_out_uv(margin_out_uv));
  margin_link_properties #(.PWRUP_CYCLES(16)) u_margin_link_properties (.sys_clk(sys_clk),
    .sys_rst(sys_rst), .host_scl_o(bus_i.host_scl_o), .host_scl_oe(bus_i.host_scl_oe),
    .host_sda_o(bus_i.host_sda_o), .host_sda_oe(bus_i.host_sda_oe),
    .dev_sda_o(bus_i.dev_sda_o), .dev_sda_oe(bus_i.dev_sda_oe), .scl(bus_i.scl),
    .sda(bus_i.sda));
  always #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    rng_state = rng_state ^ (rng_state << 13);
    rng_state = rng_state ^ (rng_state >> 17);
    rng_state = rng_state ^ (rng_state << 5);
    return rng_state;
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // issue one command, note its expected answer, wait for the response
  task automatic do_cmd(input logic rd, input logic [6:0] sa, input logic [7:0] wa,
                        input logic [15:0] wd, input logic nack, input logic [15:0] exp);
    int n;
    notes.push_back('{rd & ~nack, nack, exp});
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_slave_addr <= sa;
    cmd_word_addr <= wa;
    cmd_wdata <= wd;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 100);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 2000);
    if (n >= 2000) check("response wait", 32'h0000_0000, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic reg_wr(input logic [7:0] wa, input logic [15:0] wd);
    do_cmd(1'b0, own_addr, wa, wd, 1'b0, 16'h0000);
    if (wa == `MARGIN_CODE_OFS) code_m = wd[7:0];
    if (wa == `MARGIN_CTRL_OFS) begin
      if (wd[2] && !ctrl_m[2]) loaded_m = code_m;
      ctrl_m = wd[7:0] & `MARGIN_CTRL_MASK;
    end
  endtask
  task automatic check_out();
    int mv;
    logic [31:0] uv;
    mv = (ctrl_m[5:3] == 3'h7) ? 1200 : 400 + 100 * int'(ctrl_m[5:3]);
    uv = (ctrl_m[1] && ctrl_m[0]) ? (int'(loaded_m) * mv * 125) / 16 : 0;
    check("margin_code", {24'h00_0000, loaded_m}, {24'h00_0000, margin_code});
    check("half_scale_select", {29'h0, ctrl_m[5:3]}, {29'h0, half_scale_select});
    check("output_drive_enable", {31'h0, ctrl_m[1]}, {31'h0, output_drive_enable});
    check("converter_powered", {31'h0, ctrl_m[0]}, {31'h0, converter_powered});
    check("margin_out_uv", uv, {10'h000, margin_out_uv});
  endtask
  // response monitor: oldest note against each answer
  always @(posedge sys_clk) begin
    if (rsp_valid === 1'b1) begin
      if (notes.size() == 0) check("unexpected response", 32'h0000_0000, 32'h0000_0001);
      else begin
        seen_note = notes.pop_front();
        check("rsp_nack", {31'h0, seen_note.nack}, {31'h0, rsp_nack});
        if (seen_note.rd) check("rsp_rdata", {16'h0000, seen_note.data}, {16'h0000, rsp_rdata});
      end
    end
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    check("watchdog", 32'h0000_0000, 32'h0000_0001);
    report_and_stop();
  end
  initial begin
    logic [31:0] v;
    rng_state = 32'h0001_46c0;
    {sys_rst, clk_en, cmd_valid, cmd_read} = 4'h9 | 4'h4;
    {cmd_slave_addr, cmd_word_addr, cmd_wdata} = '0;
    {err_total, samples_checked} = '0;
    {code_m, ctrl_m, loaded_m} = '0;
    // random strap set, avoiding the reserved combinations
    do v = rnd();
    while ((v[5:4] == 2'h2 && v[3:2] == 2'h0 && v[1:0] == 2'h1) || (v[5:4] == 2'h3 && v[3]));
    {strap_high, strap_mid, strap_low} = v[5:0];
    own_addr = {`ADDR_PREFIX, v[5:0]};
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    do_cmd(1'b0, own_addr, `MARGIN_CODE_OFS, 16'h0055, 1'b1, 16'h0000);
    check_out();
    do_cmd(1'b1, own_addr, `MARGIN_CODE_OFS, 16'h0000, 1'b0, 16'h0000);
    do_cmd(1'b1, own_addr, `MARGIN_CTRL_OFS, 16'h0000, 1'b0, 16'h0000);
    $display("test powerup done");
    reg_wr(`MARGIN_CODE_OFS, 16'h0080);
    for (int i = 0; i < 8; i++) begin
      reg_wr(`MARGIN_CTRL_OFS, {10'h000, 3'(i), 3'h3});
      reg_wr(`MARGIN_CTRL_OFS, {10'h003, 3'(i), 3'h7});
      check_out();
    end
    do_cmd(1'b1, own_addr, `MARGIN_CTRL_OFS, 16'h0000, 1'b0, {8'h00, ctrl_m});
    $display("test half scale done");
    v = rnd();
    reg_wr(`MARGIN_CODE_OFS, v[15:0]);
    check_out();
    do_cmd(1'b1, own_addr, `MARGIN_CODE_OFS, 16'h0000, 1'b0, {8'h00, code_m});
    reg_wr(`MARGIN_CTRL_OFS, {8'h00, ctrl_m & 8'hfb});
    reg_wr(`MARGIN_CTRL_OFS, {8'h00, ctrl_m | 8'h04});
    check_out();
    reg_wr(`MARGIN_CTRL_OFS, {8'h00, ctrl_m & 8'hfd});
    check_out();
    reg_wr(`MARGIN_CTRL_OFS, {8'h00, (ctrl_m | 8'h02) & 8'hfe});
    check_out();
    $display("test load and gating done");
    do_cmd(1'b0, own_addr ^ 7'h01, `MARGIN_CODE_OFS, 16'h00aa, 1'b1, 16'h0000);
    do_cmd(1'b1, own_addr ^ 7'h10, `MARGIN_CTRL_OFS, 16'h0000, 1'b1, 16'h0000);
    do_cmd(1'b0, own_addr, 8'h10, 16'h1234, 1'b0, 16'h0000);
    do_cmd(1'b1, own_addr, 8'h10, 16'h0000, 1'b0, 16'h0000);
    do_cmd(1'b1, own_addr, `MARGIN_CODE_OFS, 16'h0000, 1'b0, {8'h00, code_m});
    check_out();
    $display("test addressing done");
    // freeze both ends mid-write, then reset mid-run and redo the power-up nack and code read checks
    fork
      reg_wr(`MARGIN_CODE_OFS, 16'h00c3);
      begin
        repeat (60) @(posedge sys_clk);
        clk_en <= 1'b0;
        repeat (12) @(posedge sys_clk);
        clk_en <= 1'b1;
      end
    join
    do_cmd(1'b1, own_addr, `MARGIN_CODE_OFS, 16'h0000, 1'b0, {8'h00, code_m});
    sys_rst <= 1'b1;
    {code_m, ctrl_m, loaded_m} = '0;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    do_cmd(1'b0, own_addr, `MARGIN_CODE_OFS, 16'h0055, 1'b1, 16'h0000);
    check_out();
    do_cmd(1'b1, own_addr, `MARGIN_CODE_OFS, 16'h0000, 1'b0, 16'h0000);
    $display("test freeze and reset done");
    repeat (5) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
